// ---- logic/zero_delay_output_sync.v ----
/*
 * Distribution output sync control: primary sync request, active
 * reference edge detector, feedback rollover arming, release
 * reclocking, per channel masks and the two output dividers.
 * Assumes core_clk_in is the distribution clock; the reference is
 * resampled here before use; Avalon-MM slave on the same clock.
 */
// Our own choice: the Avalon-MM interface to the registers.
// Notes on behaviour
// - Source 01 routes sync through reference edge detector, direct path off.
// - Detector watches rising edges of the currently active reference.
// - Primary request arms detector; armed output stalls unmasked dividers.
// - First reference rising edge after arming releases and restarts dividers.
// - Release is reclocked into the distribution clock before restart.
// - Restart latency is divide ratio plus four or five clocks.
// - One reference edge per request; no later tracking.
// - Each channel has a mask bit; masked channel ignores sync.
// - Masked channels run while unmasked ones stay stalled.
// - Primary request is OR of register, auto, pin, loader sources.
// - Register sync event is the one to zero transition of the bit in source 00; in 01 and 10 the zero to one transition arms.
// - Source 00: primary falling edge syncs dividers directly.
// - Source 10: primary rise arms feedback rollover detect, rollover syncs.
`timescale 1ns/10ps
`default_nettype none
`include "sync_defines.vh"
module zero_delay_output_sync #(
  parameter RATIO_WIDTH = 8
) (
  input  wire        core_clk_in,
  input  wire        sys_rst_in,
  input  wire [15:0] avs_address_in,
  input  wire        avs_read_in,
  input  wire        avs_write_in,
  input  wire [31:0] avs_writedata_in,
  input  wire [3:0]  avs_byteenable_in,
  output reg  [31:0] avs_readdata_out,
  output wire        avs_waitrequest_out,
  input  wire [3:0]  ref_in,
  input  wire [1:0]  active_ref_sel_in,
  input  wire        auto_sync_in,
  input  wire        mpin_sync_in,
  input  wire        loader_sync_in,
  input  wire        fb_rollover_in,
  output wire [1:0]  dist_clock_out,
  output wire        detector_out
);
  reg  [7:0]  ctrl_reg;
  reg         cmd_sync_reg;
  reg  [15:0] ratio_reg;
  reg         ack_reg;
  reg         prim_prev_reg;
  reg         armed_reg;
  reg         ref_meta_reg;
  reg         ref_sync_reg;
  reg         ref_prev_reg;
  reg         rel_meta_reg;
  reg         rel_sync_reg;
  reg         rel_prev_reg;
  reg         rel_pend_reg;
  reg  [31:0] rdata_next;
  wire [13:0] word_idx;
  wire        access;
  wire        wr_take;
  wire        rd_take;
  wire [1:0]  src;
  wire [1:0]  mask;
  wire        primary;
  wire        prim_rise;
  wire        prim_fall;
  wire        ref_rise;
  wire        release_evt;
  wire        release_sync;
  wire        direct_strobe;
  wire        restart;
  wire [1:0]  stalled;

  assign word_idx = avs_address_in[15:2];
  assign access   = avs_read_in | avs_write_in;
  // One wait cycle, answer on the second edge
  assign avs_waitrequest_out = access & ~ack_reg;
  assign wr_take  = avs_write_in & ack_reg;
  // Read data loaded early, stands when waitrequest drops
  assign rd_take  = avs_read_in & ~ack_reg;
  assign src  = ctrl_reg[`CTRL_SRC_MSB:`CTRL_SRC_LSB];
  assign mask = ctrl_reg[`CTRL_MASK_MSB:`CTRL_MASK_LSB];

  // Source codes that arm the detector
  function arm_source;
    input [1:0] code;
    begin
      arm_source = (code == `SRC_ACTIVE_REF) || (code == `SRC_FEEDBACK);
    end
  endfunction

  assign primary   = cmd_sync_reg | auto_sync_in | mpin_sync_in |
                     loader_sync_in;
  assign prim_rise = primary & ~prim_prev_reg;
  assign prim_fall = ~primary & prim_prev_reg;

  wire ref_active = ref_in[active_ref_sel_in];
  assign ref_rise = ref_sync_reg & ~ref_prev_reg;

  assign release_evt = armed_reg &
                       (((src == `SRC_ACTIVE_REF) && ref_rise) ||
                        ((src == `SRC_FEEDBACK) && fb_rollover_in));
  assign release_sync = rel_sync_reg & ~rel_prev_reg;

  // Direct path only in source 00
  // Direct path off in source 01
  assign direct_strobe = (src == `SRC_DIRECT) && prim_fall;
  assign restart = direct_strobe | release_sync;

  // Armed detector output
  // Stall covers arming and both reclock stages
  assign detector_out = armed_reg | rel_pend_reg;

  always @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ctrl_reg     <= `CTRL_RESET;
      cmd_sync_reg <= 1'b0;
      ratio_reg    <= `RATIO_RESET;
      ack_reg      <= 1'b0;
      avs_readdata_out <= 32'h00000000;
    end else begin
      ack_reg <= access & ~ack_reg;
      if (rd_take) begin
        avs_readdata_out <= rdata_next;
      end
      // Byte wide registers need lane 0
      if (wr_take && avs_byteenable_in[0]) begin
        case (word_idx)
          `IDX_CTRL: ctrl_reg <= avs_writedata_in[7:0] & `CTRL_WMASK;
          `IDX_CMD: cmd_sync_reg <= avs_writedata_in[`CMD_SYNC_BIT];
          `IDX_RATIO: ratio_reg[7:0] <= avs_writedata_in[7:0];
          default: ;
        endcase
      end
      // Channel 1 ratio on lane 1
      if (wr_take && avs_byteenable_in[1] && word_idx == `IDX_RATIO) begin
        ratio_reg[15:8] <= avs_writedata_in[15:8];
      end
    end
  end

  // Unmapped words read as zero
  always @* begin
    rdata_next = 32'h00000000;
    case (word_idx)
      `IDX_CTRL: rdata_next[7:0] = ctrl_reg;
      `IDX_CMD: rdata_next[`CMD_SYNC_BIT] = cmd_sync_reg;
      `IDX_RATIO: rdata_next[15:0] = ratio_reg;
      `IDX_STATUS: rdata_next[3:0] = {stalled, rel_sync_reg, armed_reg};
      default: rdata_next = 32'h00000000;
    endcase
  end

  always @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      prim_prev_reg <= 1'b0;
      armed_reg     <= 1'b0;
      ref_meta_reg  <= 1'b0;
      ref_sync_reg  <= 1'b0;
      ref_prev_reg  <= 1'b0;
      rel_meta_reg  <= 1'b0;
      rel_sync_reg  <= 1'b0;
      rel_prev_reg  <= 1'b0;
      rel_pend_reg  <= 1'b0;
    end else begin
      prim_prev_reg <= primary;
      ref_meta_reg  <= ref_active;
      ref_sync_reg  <= ref_meta_reg;
      ref_prev_reg  <= ref_sync_reg;
      if (prim_rise && arm_source(src)) begin
        armed_reg <= 1'b1;
      end else if (release_evt) begin
        armed_reg <= 1'b0;
      end
      rel_meta_reg <= release_evt;
      rel_sync_reg <= rel_meta_reg;
      rel_prev_reg <= rel_sync_reg;
      // Stall held until the release leaves the reclock stage
      if (release_evt) begin
        rel_pend_reg <= 1'b1;
      end else if (rel_sync_reg) begin
        rel_pend_reg <= 1'b0;
      end
    end
  end

  // Restart after reclock then one divider period
  // Masked channels see neither stall nor restart
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : chan
      channel_divider #(
        .RATIO_WIDTH (RATIO_WIDTH)
      ) divider (
        .core_clk_in (core_clk_in),
        .sys_rst_in  (sys_rst_in),
        .stall_in    (detector_out & ~mask[ch]),
        .restart_in  (restart & ~mask[ch]),
        .ratio_in    (ratio_reg[ch*`RATIO_CH_STRIDE +: RATIO_WIDTH]),
        .div_clk_out (dist_clock_out[ch]),
        .stalled_out (stalled[ch])
      );
    end
  endgenerate
endmodule
`default_nettype wire

// ---- include/sync_defines.vh ----
/*
 * Constants for the distribution output sync block: register indices,
 * field positions, reset values and sync source codes.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef SYNC_DEFINES_VH
`define SYNC_DEFINES_VH

// Register word indices; byte address is four times the index
`define IDX_CTRL        14'h0402
`define IDX_CMD         14'h0a02
`define IDX_RATIO       14'h0500
`define IDX_STATUS      14'h0600

// Control register fields
`define CTRL_MASK_LSB   0
`define CTRL_MASK_MSB   1
`define CTRL_SRC_LSB    4
`define CTRL_SRC_MSB    5
`define CTRL_WMASK      8'h33
`define CTRL_RESET      8'h00

// Command register field
`define CMD_SYNC_BIT    1

// Ratio register: channel 0 in [7:0], channel 1 in [15:8]
`define RATIO_RESET     16'h0101
`define RATIO_CH_STRIDE 8

// Sync source codes
`define SRC_DIRECT      2'h0
`define SRC_ACTIVE_REF  2'h1
`define SRC_FEEDBACK    2'h2

`endif

// ---- logic/channel_divider.v ----
/*
 * One output channel divider with stall and aligned restart.
 * Assumes stall and restart come from the distribution clock domain.
 */
`timescale 1ns/10ps
`default_nettype none
module channel_divider #(
  parameter RATIO_WIDTH = 8
) (
  input  wire                   core_clk_in,
  input  wire                   sys_rst_in,
  input  wire                   stall_in,
  input  wire                   restart_in,
  input  wire [RATIO_WIDTH-1:0] ratio_in,
  output reg                    div_clk_out,
  output wire                   stalled_out
);
  reg  [RATIO_WIDTH-1:0] count_reg;
  reg  [RATIO_WIDTH-1:0] count_next;
  wire [RATIO_WIDTH-1:0] last_count;
  wire [RATIO_WIDTH-1:0] half_count;

  // A ratio of zero behaves as one
  assign last_count  = (ratio_in == {RATIO_WIDTH{1'b0}}) ?
                       {RATIO_WIDTH{1'b0}} :
                       ratio_in - {{(RATIO_WIDTH-1){1'b0}}, 1'b1};
  assign half_count  = {1'b0, ratio_in[RATIO_WIDTH-1:1]};
  assign stalled_out = stall_in;

  always @* begin
    if (stall_in || restart_in || count_reg == last_count) begin
      count_next = {RATIO_WIDTH{1'b0}};
    end else begin
      count_next = count_reg + {{(RATIO_WIDTH-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      count_reg   <= {RATIO_WIDTH{1'b0}};
      div_clk_out <= 1'b0;
    end else begin
      count_reg <= count_next;
      // High during the first half of each divider period
      if (stall_in || restart_in) begin
        div_clk_out <= 1'b0;
      end else begin
        div_clk_out <= (count_next < half_count) ||
                       (half_count == {RATIO_WIDTH{1'b0}});
      end
    end
  end
endmodule
`default_nettype wire

// ---- test/ref_source_model.sv ----
/* Four free running reference inputs, staggered in phase.
   Assumes nothing of the core clock; edges land at any phase. */
`timescale 1ns/10ps
`default_nettype none
module ref_source_model (
  output logic [3:0] ref_out
);
  // Phase fixed, never stepped
  // Ring of four, 1200 ns period, 150 ns skew per input
  initial begin
    ref_out = 4'h0;
    forever #150 ref_out = {ref_out[2:0], ~ref_out[3]};
  end
endmodule
`default_nettype wire

// ---- test/zero_delay_output_sync_assertions.sv ----
/* Port checker for the output sync block, bound to its top.
   Assumes the master idles a cycle between bus requests. */
`timescale 1ns/10ps
`default_nettype none
`include "sync_defines.vh"
module zero_delay_output_sync_assertions (
  input wire logic        core_clk_in,
  input wire logic        sys_rst_in,
  input wire logic [15:0] avs_address_in,
  input wire logic        avs_read_in,
  input wire logic        avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0]  avs_byteenable_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic        avs_waitrequest_out,
  input wire logic        auto_sync_in,
  input wire logic        mpin_sync_in,
  input wire logic        loader_sync_in,
  input wire logic        fb_rollover_in,
  input wire logic [1:0]  dist_clock_out,
  input wire logic        detector_out
);
  wire logic [13:0] idx  = avs_address_in[15:2];
  wire logic        req  = avs_read_in | avs_write_in;
  wire logic        rd   = avs_read_in & ~avs_waitrequest_out;
  wire logic        wr   = avs_write_in & ~avs_waitrequest_out;
  wire logic        prim = auto_sync_in | mpin_sync_in | loader_sync_in;
  logic [7:0]       ctl_reg;
  wire logic [1:0]  src  = ctl_reg[5:4];
  // Shadow of the control register
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) ctl_reg <= 8'h00;
    else if (wr && idx == `IDX_CTRL && avs_byteenable_in[0])
      ctl_reg <= avs_writedata_in[7:0] & `CTRL_WMASK;
  end
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);
  chk_wait_first: assert property (req && !$past(req) |->
    avs_waitrequest_out) else $error("no wait in first cycle");
  chk_wait_one: assert property (req && avs_waitrequest_out |=>
    !avs_waitrequest_out) else $error("wait longer than one cycle");
  chk_unmapped_zero: assert property (rd && idx != `IDX_CTRL &&
    idx != `IDX_CMD && idx != `IDX_RATIO && idx != `IDX_STATUS |->
    avs_readdata_out == 32'h0) else $error("unmapped read not zero");
  chk_ctrl_reserved: assert property (rd && idx == `IDX_CTRL |->
    (avs_readdata_out & ~32'h33) == 32'h0) else $error("ctrl bits");
  chk_arm_cause: assert property ($rose(detector_out) |->
    (src == 2'h1 || src == 2'h2) && ($past(prim) || $past(prim, 2) ||
    $past(wr) || $past(wr, 2))) else $error("detector armed wrongly");
  chk_stall_low: assert property ($past(detector_out) &&
    detector_out |-> (dist_clock_out & ~ctl_reg[1:0]) == 2'h0)
    else $error("unmasked output runs while stalled");
  chk_disarm_hold: assert property ($fell(detector_out) |->
    !detector_out [*4]) else $error("detector rearmed itself");
  chk_ref_release: assert property (src == 2'h1 &&
    $rose(detector_out) |-> ##[1:40] !detector_out)
    else $error("no release after reference edge");
  chk_fb_release: assert property (src == 2'h2 &&
    detector_out && fb_rollover_in |-> ##[1:5] !detector_out)
    else $error("no release after rollover");
  cover property (src == 2'h1 && $fell(detector_out));
  cover property (src == 2'h2 && $fell(detector_out));
  cover property (rd && idx == `IDX_STATUS);
endmodule
bind zero_delay_output_sync zero_delay_output_sync_assertions u_chk (.*);
`default_nettype wire

// ---- test/tb_zero_delay_output_sync.sv ----
/* Self-checking bench for the output sync block over Avalon-MM.
   Assumes the reference model runs free and the checker is bound. */
`timescale 1ns/10ps
`default_nettype none
`include "sync_defines.vh"
module tb_zero_delay_output_sync;
  localparam logic [15:0] A_CTL = {`IDX_CTRL, 2'b00};
  localparam logic [15:0] A_CMD = {`IDX_CMD, 2'b00};
  localparam logic [15:0] A_RAT = {`IDX_RATIO, 2'b00};
  localparam logic [15:0] A_STA = {`IDX_STATUS, 2'b00};
  logic        core_clk_in, sys_rst_in, avs_read_in, avs_write_in, p;
  logic        auto_sync_in, mpin_sync_in, loader_sync_in, fb_rollover_in;
  logic        avs_waitrequest_out, detector_out;
  logic [15:0] avs_address_in;
  logic [31:0] avs_writedata_in, avs_readdata_out, q;
  logic [3:0]  avs_byteenable_in = 4'hf;
  logic [3:0]  ref_in;
  logic [1:0]  active_ref_sel_in, dist_clock_out;
  int          error_cnt = 0, n_compared = 0, n, tg;
  ref_source_model refs (.ref_out(ref_in));
  zero_delay_output_sync dut (.*);
  initial begin
    core_clk_in = 1'b0;
    forever #25 core_clk_in = ~core_clk_in;
  end
  task automatic tick(input int k);
    repeat (k) @(posedge core_clk_in);
  endtask
  task automatic bus(input logic w, input logic [15:0] a,
                     input logic [31:0] d);
    logic done;
    done = 1'b0;
    tick(1);
    avs_write_in <= w;
    avs_read_in <= !w;
    avs_address_in <= a;
    avs_writedata_in <= d;
    // Settled values just before the edge that samples them
    while (!done) begin
      @(negedge core_clk_in);
      done = (avs_waitrequest_out === 1'b0);
      q = avs_readdata_out;
      @(posedge core_clk_in);
    end
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (error_cnt == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #500000;
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    {sys_rst_in, avs_read_in, avs_write_in, fb_rollover_in} = 4'h8;
    {auto_sync_in, mpin_sync_in, loader_sync_in} = 3'h0;
    {avs_address_in, avs_writedata_in, active_ref_sel_in} = '0;
    tick(6);
    sys_rst_in <= 1'b0;
    bus(0, A_CTL, 0); chk(q, 32'h0);
    bus(0, A_RAT, 0); chk(q, 32'h101);
    bus(0, 16'h0004, 0); chk(q, 32'h0);
    bus(1, A_CTL, 32'hffffffff);
    bus(0, A_CTL, 0); chk(q, 32'h33);
    // Every source code against every primary input
    for (int m = 0; m < 4; m++)
      for (int i = 0; i < 3; i++) begin
        bus(1, A_CTL, m << 4);
        @(posedge ref_in[0]);
        tick(4);
        {loader_sync_in, mpin_sync_in, auto_sync_in} <= 3'h1 << i;
        tick(3);
        chk(detector_out, m == 1 || m == 2);
        {loader_sync_in, mpin_sync_in, auto_sync_in} <= 3'h0;
        fb_rollover_in <= 1'b1;
        tick(1);
        fb_rollover_in <= 1'b0;
        tick(40);
        chk(detector_out, 0);
      end
    // Channel 1 masked, sync on reference 2
    active_ref_sel_in <= 2'h2;
    bus(1, A_RAT, 32'h0203);
    bus(1, A_CTL, 32'h12);
    @(posedge ref_in[2]);
    tick(4);
    // No timing change until sync done
    bus(1, A_CMD, 32'h2);
    bus(0, A_STA, 0); chk(q[3:0], 4'h5);
    {n, tg, p} = {32'd0, 32'd0, dist_clock_out[1]};
    @(posedge ref_in[2]);
    while (dist_clock_out[0] !== 1'b1 && n < 30) begin
      tick(1);
      n++;
      @(negedge core_clk_in);
      tg += dist_clock_out[1] ^ p;
      p = dist_clock_out[1];
    end
    chk(n == 7 || n == 8, 1);
    chk(tg > 0, 1);
    tick(60);
    chk(detector_out, 0);
    bus(1, A_CMD, 0);
    tick(4);
    chk(detector_out, 0);
    // Direct source: restart on pin release, high after ratio 3 plus 1
    bus(1, A_CTL, 32'h0);
    mpin_sync_in <= 1'b1;
    tick(2);
    mpin_sync_in <= 1'b0;
    n = 0;
    do begin
      tick(1);
      n++;
      @(negedge core_clk_in);
    end while (dist_clock_out[0] !== 1'b1 && n < 30);
    chk(n, 4);
    tally_and_finish();
  end
endmodule
`default_nettype wire
